// [hw/icyt_mul_count.sv]
// Multiply step counter: derives n from the 16-bit source operand.
// Assumes a purely combinational use inside the timing block.
module icyt_mul_count #(
   parameter int W = 16
) (
   // Operand and mode
   input wire logic [W-1:0] operand,
   input wire logic signed_mode,
   // Step count
   output logic [$clog2(W+1)-1:0] n
);

   ////////////////////////////////////////////////////////////////////
   // Signed counts bit changes over operand with a zero appended below;
   // unsigned counts ones. Both share one adder chain.
   // RL6 signed bit changes
   // RL7 unsigned one bits
   always_comb
   begin
      logic [W:0] ext;
      ext = {operand, 1'b0};
      n = '0;
      for (int i = 0; i < W; i++)
      begin
         if (signed_mode)
            n = n + (ext[i+1] ^ ext[i]);
         else
            n = n + operand[i];
      end
   end

endmodule

// [hw/icyt_pkg.sv]
// Shared types and constants for the instruction cycle timing block.
// Assumes one clock domain; requesters supply effective address costs.
package icyt_pkg;

   // Operation, operand size, destination and source classes
   typedef enum logic [4:0] {
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP, OP_EOR,
      OP_SIGNED_MULTIPLY, OP_UNSIGNED_MULTIPLY, OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE,
      OP_ADD_IMMEDIATE_OP, OP_SUBI, OP_ANDI, OP_ORI, OP_EORI, OP_CMPI,
      OP_ADD_QUICK_OP, OP_SUBTRACT_QUICK_OP, OP_LOAD_QUICK_OP
   } icyt_op_t;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} icyt_size_t;
   typedef enum logic [1:0] {DST_DREG, DST_AREG, DST_MEM} icyt_dst_t;
   typedef enum logic [1:0] {SRC_DREG, SRC_AREG, SRC_MEM, SRC_IMM} icyt_src_t;

   // Request: op, classes, effective address cost and source operand
   typedef struct packed {
      icyt_op_t op;
      icyt_size_t size;
      icyt_dst_t dst;
      icyt_src_t src;
      logic [7:0] ea_clk;
      logic [3:0] ea_rd;
      logic [3:0] ea_wr;
      logic [15:0] operand;
   } icyt_req_t;

   // Result: clock periods, bus reads, bus writes, illegal form
   typedef struct packed {
      logic [9:0] clocks;
      logic [4:0] reads;
      logic [4:0] writes;
      logic err;
   } icyt_res_t;

   // Table entry: base clocks, reads, writes, extendable, legal
   typedef struct packed {
      logic [7:0] clk;
      logic [3:0] rd;
      logic [3:0] wr;
      logic ext;
      logic ok;
   } icyt_ent_t;

   localparam icyt_ent_t E_BAD = '{8'h00, 4'h0, 4'h0, 1'b0, 1'b0};
   localparam icyt_ent_t E8_20X = '{8'h08, 4'h2, 4'h0, 1'b1, 1'b1};
   localparam icyt_ent_t E10_20X = '{8'h0A, 4'h2, 4'h0, 1'b1, 1'b1};
   localparam icyt_ent_t E12_20X = '{8'h0C, 4'h2, 4'h0, 1'b1, 1'b1};
   localparam icyt_ent_t E12_21X = '{8'h0C, 4'h2, 4'h1, 1'b1, 1'b1};
   localparam icyt_ent_t E16_22X = '{8'h10, 4'h2, 4'h2, 1'b1, 1'b1};
   localparam icyt_ent_t E24_24X = '{8'h18, 4'h2, 4'h4, 1'b1, 1'b1};
   localparam icyt_ent_t E20_41X = '{8'h14, 4'h4, 4'h1, 1'b1, 1'b1};
   localparam icyt_ent_t E24_42X = '{8'h18, 4'h4, 4'h2, 1'b1, 1'b1};
   localparam icyt_ent_t E40_64X = '{8'h28, 4'h6, 4'h4, 1'b1, 1'b1};
   localparam icyt_ent_t E8_20 = '{8'h08, 4'h2, 4'h0, 1'b0, 1'b1};
   localparam icyt_ent_t E12_20 = '{8'h0C, 4'h2, 4'h0, 1'b0, 1'b1};
   localparam icyt_ent_t E16_40 = '{8'h10, 4'h4, 4'h0, 1'b0, 1'b1};
   localparam icyt_ent_t E28_60 = '{8'h1C, 4'h6, 4'h0, 1'b0, 1'b1};
   localparam icyt_ent_t E26_60 = '{8'h1A, 4'h6, 4'h0, 1'b0, 1'b1};
   localparam icyt_ent_t E24_60 = '{8'h18, 4'h6, 4'h0, 1'b0, 1'b1};
   localparam icyt_ent_t E_MUL = '{8'h4A, 4'h2, 4'h0, 1'b1, 1'b1};
   localparam icyt_ent_t E_SIGNED_DIVIDE = '{8'hA2, 4'h2, 4'h0, 1'b1, 1'b1};
   localparam icyt_ent_t E_UNSIGNED_DIVIDE = '{8'h90, 4'h2, 4'h0, 1'b1, 1'b1};

   // Long register forms, multiply and divide bounds, check operands and timer ends
   localparam logic [7:0] LONG_BASE = 8'h0A;
   localparam logic [7:0] LONG_BUMP = 8'h02;
   localparam logic [9:0] MUL_FIXED = 10'h02A;
   localparam logic [9:0] MUL_MAX = 10'h04A;
   localparam logic [9:0] SIGNED_DIVIDE_MAX = 10'h0A2;
   localparam logic [9:0] UNSIGNED_DIVIDE_MAX = 10'h090;
   localparam logic [15:0] SIGNED_MULTIPLY_WORST = 16'h5555;
   localparam logic [15:0] UNSIGNED_MULTIPLY_WORST = 16'hFFFF;
   localparam logic [3:0] IMM_READS = 4'h4;
   localparam logic [9:0] TIMER_LAST = 10'h001;
   localparam logic [9:0] TIMER_IDLE = 10'h000;

endpackage

// [hw/icyt_timing.sv]
// Instruction cycle timing engine for standard and immediate ALU forms.
// Assumes the requester supplies effective address clocks, reads, writes.
// Contract
// RL1: Every instruction reports total clocks, bus reads and bus writes.
// RL2: Extendable entries add effective address clocks, reads, writes separately.
// RL3: Standard counts cover operation, result store and next instruction fetch.
// RL4: Immediate counts also include reads fetching the immediate operand; subtract immediate to memory uses the standard memory counts instead.
// RL5: Both multiplies take 42+2n clocks, at most 74 plus address time.
// RL6: Signed multiply n counts bit changes over source with zero appended.
// RL7: Unsigned multiply n is the number of one bits in source.
// RL8: Divides take at most 162 signed, 144 unsigned; spread under 10%.
// RL9: Multiply and divide bases are maxima plus word address time.
// RL10: Long add, sub to address, or, and: 10 clocks, 12 register source. The code also gives 12 for an immediate source.
// RL11: Exclusive-or into data register accepts only data register source.
// RL12: A constant table holds base clocks, reads, writes per form.
module icyt_timing #(
   parameter int CLK_W = 10
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Request
   input wire logic req_valid,
   input wire icyt_pkg::icyt_req_t req,
   output logic req_ready,
   // Result and execution timer
   output icyt_pkg::icyt_res_t res,
   output logic busy,
   output logic done
);

   icyt_pkg::icyt_ent_t ent;
   icyt_pkg::icyt_res_t calc;
   icyt_pkg::icyt_res_t res_reg, res_next;
   logic [CLK_W-1:0] timer_reg, timer_next;
   logic [4:0] mul_n;
   logic accept;
   logic is_mul;

   ////////////////////////////////////////////////////////////////////
   // Memory destination entries, standard and immediate shapes
   function automatic icyt_pkg::icyt_ent_t mem_std(icyt_pkg::icyt_size_t s);
      return (s == icyt_pkg::SZ_BYTE) ? icyt_pkg::E12_21X :
             (s == icyt_pkg::SZ_WORD) ? icyt_pkg::E16_22X : icyt_pkg::E24_24X;
   endfunction

   function automatic icyt_pkg::icyt_ent_t mem_imm(icyt_pkg::icyt_size_t s);
      return (s == icyt_pkg::SZ_BYTE) ? icyt_pkg::E20_41X :
             (s == icyt_pkg::SZ_WORD) ? icyt_pkg::E24_42X : icyt_pkg::E40_64X;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Base table lookup
   // RL12 constant timing table
   always_comb
   begin
      logic lng;
      logic dr;
      lng = (req.size == icyt_pkg::SZ_LONG);
      dr = (req.dst == icyt_pkg::DST_DREG);
      ent = icyt_pkg::E_BAD;
      unique case (req.op)
         icyt_pkg::OP_ADD, icyt_pkg::OP_SUB, icyt_pkg::OP_AND, icyt_pkg::OP_OR:
         begin
            // RL3 store and fetch included
            if (dr)
               ent = lng ? icyt_pkg::E10_20X : icyt_pkg::E8_20X;
            else if (req.dst == icyt_pkg::DST_MEM)
               ent = mem_std(req.size);
            else if (req.op == icyt_pkg::OP_ADD || req.op == icyt_pkg::OP_SUB)
               ent = lng ? icyt_pkg::E10_20X : icyt_pkg::E12_20X;
         end
         icyt_pkg::OP_CMP:
         begin
            if (dr)
               ent = lng ? icyt_pkg::E10_20X : icyt_pkg::E8_20X;
            else if (req.dst == icyt_pkg::DST_AREG && req.size != icyt_pkg::SZ_BYTE)
               ent = icyt_pkg::E10_20X;
         end
         icyt_pkg::OP_EOR:
         begin
            // RL11 data register source only
            if (dr && req.src == icyt_pkg::SRC_DREG)
               ent = lng ? icyt_pkg::E12_20X : icyt_pkg::E8_20X;
            else if (req.dst == icyt_pkg::DST_MEM)
               ent = mem_std(req.size);
         end
         icyt_pkg::OP_SIGNED_MULTIPLY, icyt_pkg::OP_UNSIGNED_MULTIPLY:
         begin
            if (dr && req.size == icyt_pkg::SZ_WORD)
               ent = icyt_pkg::E_MUL;
         end
         icyt_pkg::OP_SIGNED_DIVIDE, icyt_pkg::OP_UNSIGNED_DIVIDE:
         begin
            // RL8 worst case divide bases
            if (dr && req.size == icyt_pkg::SZ_WORD)
               ent = (req.op == icyt_pkg::OP_SIGNED_DIVIDE) ? icyt_pkg::E_SIGNED_DIVIDE : icyt_pkg::E_UNSIGNED_DIVIDE;
         end
         icyt_pkg::OP_ADD_IMMEDIATE_OP, icyt_pkg::OP_ANDI, icyt_pkg::OP_ORI, icyt_pkg::OP_EORI,
         icyt_pkg::OP_SUBI:
         begin
            // RL4 immediate fetch reads, except subtract immediate to memory, which takes the standard memory shape
            if (dr)
               ent = lng ? icyt_pkg::E28_60 : icyt_pkg::E16_40;
            else if (req.dst == icyt_pkg::DST_MEM)
               ent = (req.op == icyt_pkg::OP_SUBI) ? mem_std(req.size) : mem_imm(req.size);
         end
         icyt_pkg::OP_CMPI:
         begin
            if (dr)
               ent = lng ? icyt_pkg::E26_60 : icyt_pkg::E16_40;
            else if (req.dst == icyt_pkg::DST_MEM)
               ent = lng ? icyt_pkg::E24_60 : icyt_pkg::E16_40;
         end
         icyt_pkg::OP_ADD_QUICK_OP, icyt_pkg::OP_SUBTRACT_QUICK_OP:
         begin
            if (dr)
               ent = lng ? icyt_pkg::E12_20 : icyt_pkg::E8_20;
            else if (req.dst == icyt_pkg::DST_AREG && req.size != icyt_pkg::SZ_BYTE)
               ent = icyt_pkg::E12_20;
            else if (req.dst == icyt_pkg::DST_MEM)
               ent = (req.op == icyt_pkg::OP_ADD_QUICK_OP) ? mem_std(req.size) : mem_imm(req.size);
         end
         icyt_pkg::OP_LOAD_QUICK_OP:
         begin
            if (dr && lng)
               ent = icyt_pkg::E8_20;
         end
         default:
            ent = icyt_pkg::E_BAD;
      endcase
   end

   // Multiply step count from the source operand
   icyt_mul_count #(.W(16)) u_mul_count (
      .operand(req.operand),
      .signed_mode(req.op == icyt_pkg::OP_SIGNED_MULTIPLY),
      .n(mul_n)
   );

   assign is_mul = (req.op == icyt_pkg::OP_SIGNED_MULTIPLY) || (req.op == icyt_pkg::OP_UNSIGNED_MULTIPLY);

   ////////////////////////////////////////////////////////////////////
   // Totals; multiply replaces its table maximum by the real count
   always_comb
   begin
      logic [9:0] base;
      base = {2'b00, ent.clk};
      // RL10 long register or immediate source bump
      if (ent.clk == icyt_pkg::LONG_BASE && req.op != icyt_pkg::OP_CMP
          && req.src != icyt_pkg::SRC_MEM)
         base = {2'b00, ent.clk + icyt_pkg::LONG_BUMP};
      // RL5 multiply duration formula
      if (is_mul)
         base = icyt_pkg::MUL_FIXED + {4'h0, mul_n, 1'b0};
      calc.err = !ent.ok;
      calc.clocks = ent.ok ? base : '0;
      calc.reads = {1'b0, ent.rd};
      calc.writes = {1'b0, ent.wr};
      // RL2 add address cost
      // RL9 word address time added
      if (ent.ext)
      begin
         calc.clocks = base + {2'b00, req.ea_clk};
         calc.reads = {1'b0, ent.rd} + {1'b0, req.ea_rd};
         calc.writes = {1'b0, ent.wr} + {1'b0, req.ea_wr};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Result register and execution timer; one instruction at a time
   // so a new request waits until the previous one has spent its clocks
   assign accept = req_valid && req_ready;

   always_comb
   begin
      res_next = res_reg;
      timer_next = (timer_reg != icyt_pkg::TIMER_IDLE) ? timer_reg - 1'b1 : timer_reg;
      // RL1 three counts recorded
      if (accept)
      begin
         res_next = calc;
         timer_next = CLK_W'(calc.clocks);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         res_reg <= '0;
         timer_reg <= '0;
      end
      else
      begin
         res_reg <= res_next;
         timer_reg <= timer_next;
      end
   end

   assign res = res_reg;
   assign busy = (timer_reg != icyt_pkg::TIMER_IDLE);
   assign done = (timer_reg == icyt_pkg::TIMER_LAST);
   assign req_ready = !busy;

   ////////////////////////////////////////////////////////////////////
   // Checks on the reported counts and the timer
   property p_counts;
      @(posedge clk_sys) disable iff (!resetn)
      accept && ent.ok |=> busy && res.clocks != '0 && res.reads != '0;
   endproperty
   a_counts: assert property (p_counts) else $error("legal form gave no counts"); // RL1

   property p_ext_sum;
      @(posedge clk_sys) disable iff (!resetn)
      accept && ent.ext && !is_mul |=> res.reads == $past(ent.rd) + $past(req.ea_rd)
         && res.writes == $past(ent.wr) + $past(req.ea_wr);
   endproperty
   a_ext_sum: assert property (p_ext_sum) else $error("address cost not summed"); // RL2

   property p_mem_store;
      @(posedge clk_sys) disable iff (!resetn)
      accept && req.dst == icyt_pkg::DST_MEM && req.op == icyt_pkg::OP_ADD
      |=> res.writes != '0;
   endproperty
   a_mem_store: assert property (p_mem_store) else $error("memory store not counted"); // RL3

   property p_imm_reads;
      @(posedge clk_sys) disable iff (!resetn)
      accept && req.op == icyt_pkg::OP_ADD_IMMEDIATE_OP && req.dst == icyt_pkg::DST_DREG
      |=> res.reads >= icyt_pkg::IMM_READS;
   endproperty
   a_imm_reads: assert property (p_imm_reads) else $error("immediate fetch missing"); // RL4

   property p_mul_bound;
      @(posedge clk_sys) disable iff (!resetn)
      accept && is_mul && ent.ok |=> res.clocks <= icyt_pkg::MUL_MAX + $past(req.ea_clk);
   endproperty
   a_mul_bound: assert property (p_mul_bound) else $error("multiply above maximum"); // RL5

   property p_signed_multiply_worst;
      @(posedge clk_sys) disable iff (!resetn)
      accept && ent.ok && req.op == icyt_pkg::OP_SIGNED_MULTIPLY && req.operand == icyt_pkg::SIGNED_MULTIPLY_WORST
      |=> res.clocks == icyt_pkg::MUL_MAX + $past(req.ea_clk);
   endproperty
   a_signed_multiply_worst: assert property (p_signed_multiply_worst) else $error("signed worst case wrong"); // RL6

   property p_unsigned_multiply_worst;
      @(posedge clk_sys) disable iff (!resetn)
      accept && ent.ok && req.op == icyt_pkg::OP_UNSIGNED_MULTIPLY && req.operand == icyt_pkg::UNSIGNED_MULTIPLY_WORST
      |=> res.clocks == icyt_pkg::MUL_MAX + $past(req.ea_clk);
   endproperty
   a_unsigned_multiply_worst: assert property (p_unsigned_multiply_worst) else $error("unsigned worst case wrong"); // RL7

   property p_div;
      @(posedge clk_sys) disable iff (!resetn)
      accept && ent.ok && req.op == icyt_pkg::OP_SIGNED_DIVIDE
      |=> res.clocks == icyt_pkg::SIGNED_DIVIDE_MAX + $past(req.ea_clk);
   endproperty
   a_div: assert property (p_div) else $error("signed divide count wrong"); // RL8

   property p_unsigned_divide;
      @(posedge clk_sys) disable iff (!resetn)
      accept && ent.ok && req.op == icyt_pkg::OP_UNSIGNED_DIVIDE
      |=> res.clocks == icyt_pkg::UNSIGNED_DIVIDE_MAX + $past(req.ea_clk); 
   endproperty
   a_unsigned_divide: assert property (p_unsigned_divide) else $error("unsigned divide count wrong"); // RL9

   property p_long_bump;
      @(posedge clk_sys) disable iff (!resetn)
      accept && req.op == icyt_pkg::OP_OR && req.dst == icyt_pkg::DST_DREG
      && req.size == icyt_pkg::SZ_LONG && req.src == icyt_pkg::SRC_IMM
      |=> res.clocks == icyt_pkg::LONG_BASE + icyt_pkg::LONG_BUMP + $past(req.ea_clk);
   endproperty
   a_long_bump: assert property (p_long_bump) else $error("long register bump missing"); // RL10

   property p_eor_src;
      @(posedge clk_sys) disable iff (!resetn)
      accept && req.op == icyt_pkg::OP_EOR && req.dst == icyt_pkg::DST_DREG
      && req.src != icyt_pkg::SRC_DREG |=> res.err && !busy;
   endproperty
   a_eor_src: assert property (p_eor_src) else $error("bad exclusive-or source taken"); // RL11

   property p_timer;
      @(posedge clk_sys) disable iff (!resetn)
      accept && ent.ok && req.op == icyt_pkg::OP_LOAD_QUICK_OP |=> busy [*7] ##1 done ##1 !busy;
   endproperty
   a_timer: assert property (p_timer) else $error("timer length wrong"); // RL12

endmodule

// [verif/icyt_ea_src.sv]
// Effective address cost source standing in for the operand fetch side.
// Assumes the bench selects memory modes; register modes cost nothing.
module icyt_ea_src #(
   parameter logic [7:0] EA_CLK = 8'h04,
   parameter logic [3:0] EA_RD = 4'h1,
   parameter logic [3:0] EA_WR = 4'h1
) (
   // Mode select
   input wire logic use_mem,
   // Address calculation cost
   output logic [7:0] ea_clk,
   output logic [3:0] ea_rd,
   output logic [3:0] ea_wr
);
   ////////////////////////////////////////////////////////////////////////////////
   // A write in the cost proves writes are summed apart from reads
   assign ea_clk = use_mem ? EA_CLK : 8'h00;
   assign ea_rd = use_mem ? EA_RD : 4'h0;
   assign ea_wr = use_mem ? EA_WR : 4'h0;
endmodule

// [verif/testbench.sv]
// Self-checking bench for the instruction cycle timing engine.
// Assumes the engine, its package and the address cost model are compiled first.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys;
   logic resetn;
   logic req_valid;
   logic use_mem;
   icyt_pkg::icyt_req_t req;
   logic req_ready;
   icyt_pkg::icyt_res_t res;
   logic busy;
   logic done;
   logic [7:0] m_clk;
   logic [3:0] m_rd;
   logic [3:0] m_wr;
   int bad_count;
   int tests_run;

   ////////////////////////////////////////////////////////////////////////////////
   // Engine and cost model
   icyt_timing #(.CLK_W(10)) uut (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .res(res), .busy(busy), .done(done));
   icyt_ea_src ea_model (.use_mem(use_mem), .ea_clk(m_clk), .ea_rd(m_rd), .ea_wr(m_wr));

   // Free running clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Count busy cycles and done pulses; bounded so a stuck timer cannot hang
   task automatic idle(output int n, output int d);
      n = 0;
      d = 0;
      while (busy === 1'b1 && n < 400)
      begin
         n++;
         if (done === 1'b1)
            d++;
         @(negedge clk_sys);
      end
   endtask

   // One request, entered at a falling edge while the engine is idle
   task automatic run(input icyt_pkg::icyt_op_t op, input icyt_pkg::icyt_size_t sz,
      input icyt_pkg::icyt_dst_t dst, input icyt_pkg::icyt_src_t src, input logic [15:0] opd,
      input logic [7:0] base, input logic [3:0] rd, input logic [3:0] wr, input logic ext,
      input logic err);
      int n;
      int d;
      logic [9:0] ec;
      logic [9:0] er;
      logic [9:0] ew;
      ec = {2'h0, base} + (ext ? {2'h0, m_clk} : 10'h000);
      er = {6'h00, rd} + (ext ? {6'h00, m_rd} : 10'h000);
      ew = {6'h00, wr} + (ext ? {6'h00, m_wr} : 10'h000);
      req = '{op, sz, dst, src, m_clk, m_rd, m_wr, opd};
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      check(res.clocks, ec, "clocks");
      check({5'h00, res.reads}, er, "reads");
      check({5'h00, res.writes}, ew, "writes");
      check({9'h000, res.err}, {9'h000, err}, "illegal form");
      idle(n, d);
      check(n[9:0], ec, "busy span");
      check(d[9:0], {9'h000, ~err}, "done pulses");
      check({9'h000, req_ready}, 10'h001, "ready after");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_standard;
      run(icyt_pkg::OP_ADD, icyt_pkg::SZ_LONG, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'h0000, 8'h0A, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_ADD, icyt_pkg::SZ_LONG, icyt_pkg::DST_DREG, icyt_pkg::SRC_DREG,
         16'h0000, 8'h0C, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_SUB, icyt_pkg::SZ_LONG, icyt_pkg::DST_AREG, icyt_pkg::SRC_IMM,
         16'h0000, 8'h0C, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_CMP, icyt_pkg::SZ_LONG, icyt_pkg::DST_DREG, icyt_pkg::SRC_DREG,
         16'h0000, 8'h0A, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_ADD, icyt_pkg::SZ_WORD, icyt_pkg::DST_MEM, icyt_pkg::SRC_DREG,
         16'h0000, 8'h10, 4'h2, 4'h2, 1'b1, 1'b0);
      run(icyt_pkg::OP_OR, icyt_pkg::SZ_LONG, icyt_pkg::DST_DREG, icyt_pkg::SRC_IMM,
         16'h0000, 8'h0C, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_EOR, icyt_pkg::SZ_LONG, icyt_pkg::DST_DREG, icyt_pkg::SRC_DREG,
         16'h0000, 8'h0C, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_EOR, icyt_pkg::SZ_WORD, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'h0000, 8'h00, 4'h0, 4'h0, 1'b0, 1'b1);
      $display("standard forms done");
   endtask

   task automatic t_immediate;
      run(icyt_pkg::OP_ADD_IMMEDIATE_OP, icyt_pkg::SZ_LONG, icyt_pkg::DST_MEM, icyt_pkg::SRC_IMM,
         16'h0000, 8'h28, 4'h6, 4'h4, 1'b1, 1'b0);
      run(icyt_pkg::OP_ADD_IMMEDIATE_OP, icyt_pkg::SZ_WORD, icyt_pkg::DST_DREG, icyt_pkg::SRC_IMM,
         16'h0000, 8'h10, 4'h4, 4'h0, 1'b0, 1'b0);
      run(icyt_pkg::OP_CMPI, icyt_pkg::SZ_LONG, icyt_pkg::DST_MEM, icyt_pkg::SRC_IMM,
         16'h0000, 8'h18, 4'h6, 4'h0, 1'b0, 1'b0);
      run(icyt_pkg::OP_SUBTRACT_QUICK_OP, icyt_pkg::SZ_LONG, icyt_pkg::DST_MEM, icyt_pkg::SRC_IMM,
         16'h0000, 8'h28, 4'h6, 4'h4, 1'b1, 1'b0);
      run(icyt_pkg::OP_ORI, icyt_pkg::SZ_LONG, icyt_pkg::DST_DREG, icyt_pkg::SRC_IMM,
         16'h0000, 8'h1C, 4'h6, 4'h0, 1'b0, 1'b0);
      run(icyt_pkg::OP_LOAD_QUICK_OP, icyt_pkg::SZ_LONG, icyt_pkg::DST_DREG, icyt_pkg::SRC_IMM,
         16'h0000, 8'h08, 4'h2, 4'h0, 1'b0, 1'b0);
      $display("immediate forms done");
   endtask

   task automatic t_muldiv;
      run(icyt_pkg::OP_SIGNED_MULTIPLY, icyt_pkg::SZ_WORD, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'h5555, 8'h4A, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_SIGNED_MULTIPLY, icyt_pkg::SZ_WORD, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'h0001, 8'h2E, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_UNSIGNED_MULTIPLY, icyt_pkg::SZ_WORD, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'h00F0, 8'h32, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_UNSIGNED_MULTIPLY, icyt_pkg::SZ_WORD, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'hFFFF, 8'h4A, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_UNSIGNED_MULTIPLY, icyt_pkg::SZ_BYTE, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'h00F0, 8'h00, 4'h0, 4'h0, 1'b0, 1'b1);
      run(icyt_pkg::OP_SIGNED_DIVIDE, icyt_pkg::SZ_WORD, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'h1234, 8'hA2, 4'h2, 4'h0, 1'b1, 1'b0);
      run(icyt_pkg::OP_UNSIGNED_DIVIDE, icyt_pkg::SZ_WORD, icyt_pkg::DST_DREG, icyt_pkg::SRC_MEM,
         16'h1234, 8'h90, 4'h2, 4'h0, 1'b1, 1'b0);
      $display("multiply and divide done");
   endtask

   // Request held through a busy span must not be taken until the timer ends
   task automatic t_refuse;
      int n;
      int d;
      req = '{icyt_pkg::OP_LOAD_QUICK_OP, icyt_pkg::SZ_LONG, icyt_pkg::DST_DREG, icyt_pkg::SRC_IMM,
         m_clk, m_rd, m_wr, 16'h0000};
      req_valid = 1'b1;
      @(negedge clk_sys);
      req.op = icyt_pkg::OP_UNSIGNED_DIVIDE;
      req.size = icyt_pkg::SZ_WORD;
      idle(n, d);
      check(n[9:0], 10'h008, "span while held");
      check(res.clocks, 10'h008, "result held");
      @(negedge clk_sys);
      req_valid = 1'b0;
      check(res.clocks, 10'h090 + {2'h0, m_clk}, "taken after done");
      idle(n, d);
      $display("held request done");
   endtask

   // Reset in mid instruction clears the timer and result at once
   task automatic t_abort;
      req.op = icyt_pkg::OP_SIGNED_DIVIDE;
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      repeat (3) @(negedge clk_sys);
      resetn = 1'b0;
      #1;
      check({9'h000, busy}, 10'h000, "busy in reset");
      check(res.clocks, 10'h000, "result in reset");
      check({9'h000, req_ready}, 10'h001, "ready in reset");
      @(negedge clk_sys);
      resetn = 1'b1;
      $display("reset abort done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog at 20000 cycles, well beyond the roughly 1200 cycles the tests need
   initial
   begin
      #200000;
      bad_count++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      resetn = 1'b0;
      req_valid = 1'b0;
      use_mem = 1'b1;
      req = '0;
      bad_count = 0;
      tests_run = 0;
      repeat (4) @(negedge clk_sys);
      resetn = 1'b1;
      t_standard();
      t_immediate();
      t_muldiv();
      t_refuse();
      t_abort();
      t_standard();
      stop_test();
   end
endmodule
